// ===== logic/ccs_core.sv
/*
 * Core sequencer and register file front end: four phase generator,
 * fetch/execute pipeline, program counter and data register file.
 * Assumes a combinational program ROM, and an execution unit on mclk
 * holding the exec_* inputs through each cycle with instr_valid high.
 */
`timescale 1ns/1ps
module ccs_core
   import ccs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   output logic phase_one,
   output logic phase_two,
   output logic phase_three,
   output logic phase_four,
   output logic [ccs_pkg::PC_W-1:0] rom_addr,
   input wire logic [ccs_pkg::INSTR_W-1:0] rom_data,
   output logic [ccs_pkg::INSTR_W-1:0] instr,
   output logic instr_valid,
   input wire logic [ccs_pkg::FADDR_W-1:0] exec_src_addr,
   output logic [ccs_pkg::DATA_W-1:0] exec_src_data,
   input wire logic exec_wr_en,
   input wire logic [ccs_pkg::FADDR_W-1:0] exec_dst_addr,
   input wire logic [ccs_pkg::DATA_W-1:0] exec_wr_data,
   input wire logic [2:0] exec_flag_mask,
   input wire logic [2:0] exec_flag_value,
   input wire logic exec_branch,
   input wire logic exec_call,
   input wire logic [ccs_pkg::PC_W-1:0] exec_branch_target,
   input wire logic exec_option_wr,
   input wire logic exec_dir_wr,
   input wire logic exec_dir_sel,
   input wire logic reset_flag_load,
   input wire logic timeout_flag_in,
   input wire logic power_down_flag_in,
   output logic [ccs_pkg::OPTION_W-1:0] timer_prescaler_config,
   output logic [2:0] page_select,
   input wire logic [ccs_pkg::PORT_A_W-1:0] first_port_in,
   output logic [ccs_pkg::PORT_A_W-1:0] first_port_out,
   output logic [ccs_pkg::PORT_A_W-1:0] first_port_oe_n,
   input wire logic [ccs_pkg::DATA_W-1:0] second_port_in,
   output logic [ccs_pkg::DATA_W-1:0] second_port_out,
   output logic [ccs_pkg::DATA_W-1:0] second_port_oe_n
);

   ccs_phase_e phase;
   logic [PC_W-1:0] program_address_counter;
   logic [INSTR_W-1:0] instruction_holding_register;
   logic prefetch_valid;
   logic [DATA_W-1:0] realtime_counter;
   logic [DATA_W-1:0] core_flags;
   logic [DATA_W-1:0] indirect_pointer;
   logic [PORT_A_W-1:0] first_port_latch;
   logic [DATA_W-1:0] second_port_latch;
   logic [PORT_A_W-1:0] first_port_dir;
   logic [DATA_W-1:0] second_port_dir;
   logic [PORT_A_W-1:0] first_port_meta;
   logic [PORT_A_W-1:0] first_port_sync;
   logic [DATA_W-1:0] second_port_meta;
   logic [DATA_W-1:0] second_port_sync;
   logic [FADDR_W-1:0] src_eff;
   logic [FADDR_W-1:0] dst_eff;
   logic [DATA_W-1:0] gp_rd_data;
   logic [DATA_W-1:0] next_src_data;
   logic do_write;
   logic wr_counter_low;
   logic wr_flags;
   logic redirect;
   logic [PC_W-1:0] next_target;
   logic [2:0] next_arith;

   assign phase_one = (phase == PH_ONE);
   assign phase_two = (phase == PH_TWO);
   assign phase_three = (phase == PH_THREE);
   assign phase_four = (phase == PH_FOUR);
   assign instr = instruction_holding_register;
   assign instr_valid = prefetch_valid;

   // Phase sequencer, one clock per phase
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         phase <= PH_ONE;
      end
      else
      begin
         case (phase)
            PH_ONE: phase <= PH_TWO;
            PH_TWO: phase <= PH_THREE;
            PH_THREE: phase <= PH_FOUR;
            PH_FOUR: phase <= PH_ONE;
            default: phase <= PH_ONE;
         endcase
      end
   end

   // Address 00h redirects through the pointer
   assign src_eff = (exec_src_addr == ADDR_INDIRECT_ACCESS_PORT) ?
      indirect_pointer[FADDR_W-1:0] : exec_src_addr;
   assign dst_eff = (exec_dst_addr == ADDR_INDIRECT_ACCESS_PORT) ?
      indirect_pointer[FADDR_W-1:0] : exec_dst_addr;

   // Writes land only at the end of phase four of a valid instruction
   assign do_write = phase_four && prefetch_valid && exec_wr_en;
   assign wr_counter_low = do_write &&
      (dst_eff == ADDR_PROGRAM_COUNTER_LOW);
   assign wr_flags = do_write && (dst_eff == ADDR_CORE_FLAGS);
   assign redirect = phase_four && prefetch_valid &&
      (exec_branch || wr_counter_low);

   always_comb
   begin
      next_target = exec_branch_target;
      if (wr_counter_low)
      begin
         next_target = {1'b0, exec_wr_data};
      end
      else if (exec_call)
      begin
         next_target = {1'b0, exec_branch_target[DATA_W-1:0]};
      end
   end

   // Counter: 9-bit wrap gives 1FFh -> 000h after the reset vector
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         program_address_counter <= RST_PROGRAM_COUNTER;
         rom_addr <= RST_PROGRAM_COUNTER;
      end
      else if (phase_one)
      begin
         rom_addr <= program_address_counter;
         program_address_counter <=
            program_address_counter + 9'h001;
      end
      else if (redirect)
      begin
         program_address_counter <= next_target;
      end
   end

   // Prefetch latch; a redirect discards the word arriving with it
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         instruction_holding_register <= 12'h000;
         prefetch_valid <= 1'b0;
      end
      else if (phase_four)
      begin
         instruction_holding_register <= rom_data;
         prefetch_valid <= !redirect;
      end
   end

   ccs_gp_file u_gp_file (
      .mclk(mclk),
      .wr_en(do_write),
      .wr_addr(dst_eff),
      .wr_data(exec_wr_data),
      .rd_addr(src_eff),
      .rd_data(gp_rd_data)
   );

   // Read mux; pointer at 00h itself reads zero
   always_comb
   begin
      case (src_eff)
         ADDR_INDIRECT_ACCESS_PORT: next_src_data = 8'h00;
         ADDR_REALTIME_COUNTER: next_src_data = realtime_counter;
         ADDR_PROGRAM_COUNTER_LOW:
            next_src_data = program_address_counter[DATA_W-1:0];
         ADDR_CORE_FLAGS: next_src_data = core_flags;
         ADDR_INDIRECT_POINTER: next_src_data = indirect_pointer;
         ADDR_PORT_A_PINS:
            next_src_data = {4'h0, first_port_sync};
         ADDR_PORT_B_PINS: next_src_data = second_port_sync;
         default: next_src_data = gp_rd_data;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         exec_src_data <= 8'h00;
      end
      else if (phase_two)
      begin
         exec_src_data <= next_src_data;
      end
   end

   // Timer value held here only; counting lives elsewhere
   always_ff @(posedge mclk)
   begin
      if (do_write && dst_eff == ADDR_REALTIME_COUNTER)
      begin
         realtime_counter <= exec_wr_data;
      end
   end

   // Pointer: low bits survive resets, top bit forced
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         indirect_pointer[PTR_TOP] <= RST_PTR_TOP;
      end
      else if (do_write && dst_eff == ADDR_INDIRECT_POINTER)
      begin
         indirect_pointer <= exec_wr_data;
      end
   end

   // Status: one process owns every bit, so no split drivers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         core_flags[ST_PAGE_HIGH:ST_PAGE_LOW] <= RST_PAGE_SELECT;
      end
      else if (wr_flags)
      begin
         core_flags[ST_PAGE_HIGH:ST_PAGE_LOW] <=
            exec_wr_data[ST_PAGE_HIGH:ST_PAGE_LOW];
      end
      // Only the reset and low-power logic reach these
      if (reset_flag_load)
      begin
         core_flags[ST_TIMEOUT] <= timeout_flag_in;
         core_flags[ST_POWER_DOWN] <= power_down_flag_in;
      end
      core_flags[ST_ZERO:ST_CARRY] <= next_arith;
   end

   // Arithmetic flags: operation result beats written data
   genvar fi;
   generate
      for (fi = 0; fi < 3; fi++)
      begin : g_flag
         assign next_arith[fi] =
            (phase_four && prefetch_valid && exec_flag_mask[fi]) ?
            exec_flag_value[fi] :
            (wr_flags && exec_flag_mask == 3'h0) ?
            exec_wr_data[fi] : core_flags[fi];
      end
   endgenerate

   assign page_select = core_flags[ST_PAGE_HIGH:ST_PAGE_LOW];

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         timer_prescaler_config <= RST_TIMER_PRESCALER;
      end
      else if (phase_four && prefetch_valid && exec_option_wr)
      begin
         timer_prescaler_config <= exec_wr_data[OPTION_W-1:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         first_port_dir <= RST_PORT_A_DIRECTION;
         second_port_dir <= RST_PORT_DIRECTION;
      end
      else if (phase_four && prefetch_valid && exec_dir_wr)
      begin
         if (exec_dir_sel)
         begin
            second_port_dir <= exec_wr_data;
         end
         else
         begin
            first_port_dir <= exec_wr_data[PORT_A_W-1:0];
         end
      end
   end

   // Output latches keep their value over resets
   always_ff @(posedge mclk)
   begin
      if (do_write && dst_eff == ADDR_PORT_A_PINS)
      begin
         first_port_latch <= exec_wr_data[PORT_A_W-1:0];
      end
      if (do_write && dst_eff == ADDR_PORT_B_PINS)
      begin
         second_port_latch <= exec_wr_data;
      end
   end

   // Pin inputs cross in through two flops
   always_ff @(posedge mclk)
   begin
      first_port_meta <= first_port_in;
      first_port_sync <= first_port_meta;
      second_port_meta <= second_port_in;
      second_port_sync <= second_port_meta;
   end

   assign first_port_out = first_port_latch;
   assign second_port_out = second_port_latch;
   assign first_port_oe_n = first_port_dir;
   assign second_port_oe_n = second_port_dir;

endmodule

// ===== logic/ccs_gp_file.sv
/*
 * General purpose byte registers at data addresses 07h to 1Fh.
 * Writes to addresses below that range are ignored, and reads
 * of those addresses return zero.
 */
`timescale 1ns/1ps
module ccs_gp_file
   import ccs_pkg::*;
(
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [ccs_pkg::FADDR_W-1:0] wr_addr,
   input wire logic [ccs_pkg::DATA_W-1:0] wr_data,
   input wire logic [ccs_pkg::FADDR_W-1:0] rd_addr,
   output logic [ccs_pkg::DATA_W-1:0] rd_data
);

   // No reset: contents are unknown at power-on, kept over other resets
   logic [DATA_W-1:0] mem [0:GP_COUNT-1];
   logic [FADDR_W-1:0] wr_index;
   logic [FADDR_W-1:0] rd_index;

   assign wr_index = wr_addr - ADDR_GP_FIRST;
   assign rd_index = rd_addr - ADDR_GP_FIRST;

   always_ff @(posedge mclk)
   begin
      if (wr_en && wr_addr >= ADDR_GP_FIRST)
      begin
         mem[wr_index] <= wr_data;
      end
   end

   always_comb
   begin
      rd_data = 8'h00;
      if (rd_addr >= ADDR_GP_FIRST)
      begin
         rd_data = mem[rd_index];
      end
   end

endmodule

// ===== logic/ccs_pkg.sv
/*
 * Shared constants for the core sequencer and register file: widths,
 * data addresses, status bit positions and reset values.
 * Assumes nothing of its surroundings.
 */
package ccs_pkg;

   localparam int PC_W = 9;
   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   localparam int GP_COUNT = 25;
   localparam int OPTION_W = 6;
   localparam int PORT_A_W = 4;

   // Data memory addresses
   localparam logic [4:0] ADDR_INDIRECT_ACCESS_PORT = 5'h00;
   localparam logic [4:0] ADDR_REALTIME_COUNTER = 5'h01;
   localparam logic [4:0] ADDR_PROGRAM_COUNTER_LOW = 5'h02;
   localparam logic [4:0] ADDR_CORE_FLAGS = 5'h03;
   localparam logic [4:0] ADDR_INDIRECT_POINTER = 5'h04;
   localparam logic [4:0] ADDR_PORT_A_PINS = 5'h05;
   localparam logic [4:0] ADDR_PORT_B_PINS = 5'h06;
   localparam logic [4:0] ADDR_GP_FIRST = 5'h07;

   // Status and pointer bit positions
   localparam int ST_PAGE_HIGH = 7;
   localparam int ST_PAGE_LOW = 5;
   localparam int ST_TIMEOUT = 4;
   localparam int ST_POWER_DOWN = 3;
   localparam int ST_ZERO = 2;
   localparam int ST_DIGIT_CARRY = 1;
   localparam int ST_CARRY = 0;
   localparam int PTR_TOP = 7;

   // Reset values
   localparam logic [8:0] RST_PROGRAM_COUNTER = 9'h1ff;
   localparam logic [2:0] RST_PAGE_SELECT = 3'h0;
   localparam logic [7:0] RST_PORT_DIRECTION = 8'hff;
   localparam logic [3:0] RST_PORT_A_DIRECTION = 4'hf;
   localparam logic [5:0] RST_TIMER_PRESCALER = 6'h3f;
   localparam logic RST_PTR_TOP = 1'b1;

   typedef enum logic [1:0] {
      PH_ONE,
      PH_TWO,
      PH_THREE,
      PH_FOUR
   } ccs_phase_e;

endpackage

// ===== testbench/ccs_core_sva.sv
/*
 * Port checker for ccs_core.
 * Assumes it is bound onto ccs_core and sees only its ports.
 */
`timescale 1ns/1ps
module ccs_core_sva
   import ccs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic phase_one,
   input wire logic phase_two,
   input wire logic phase_three,
   input wire logic phase_four,
   input wire logic [ccs_pkg::PC_W-1:0] rom_addr,
   input wire logic [ccs_pkg::INSTR_W-1:0] rom_data,
   input wire logic [ccs_pkg::INSTR_W-1:0] instr,
   input wire logic instr_valid,
   input wire logic [ccs_pkg::DATA_W-1:0] exec_src_data,
   input wire logic exec_wr_en,
   input wire logic [ccs_pkg::FADDR_W-1:0] exec_dst_addr,
   input wire logic [ccs_pkg::DATA_W-1:0] exec_wr_data,
   input wire logic exec_branch,
   input wire logic exec_call,
   input wire logic [ccs_pkg::PC_W-1:0] exec_branch_target,
   input wire logic exec_option_wr,
   input wire logic [ccs_pkg::OPTION_W-1:0] timer_prescaler_config,
   input wire logic [2:0] page_select,
   input wire logic [ccs_pkg::PORT_A_W-1:0] first_port_oe_n,
   input wire logic [ccs_pkg::DATA_W-1:0] second_port_oe_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   wire logic go = phase_four && instr_valid;
   // Low byte writes redirect just like jumps
   wire logic redir = exec_branch ||
      (exec_wr_en && exec_dst_addr == ADDR_PROGRAM_COUNTER_LOW);

   a_phase_walk: assert property (
      phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
      else $error("phase walk broken");
   a_addr_hold: assert property (
      !phase_one |=> $stable(rom_addr))
      else $error("fetch address moved outside phase one");
   a_ir_load: assert property (
      phase_four && !(go && redir) |=> instr_valid
      && instr == $past(rom_data))
      else $error("fetched word not latched");
   a_jump_flush: assert property (
      go && exec_branch && !exec_call |=> !instr_valid
      ##1 rom_addr == $past(exec_branch_target, 2))
      else $error("jump not flushed or wrong target");
   a_call_page: assert property (
      go && exec_branch && exec_call |=> ##1
      rom_addr == ($past(exec_branch_target, 2) & 9'h0ff))
      else $error("call kept counter bit 8");
   a_src_hold: assert property (
      !phase_two |=> $stable(exec_src_data))
      else $error("operand changed outside phase two");
   a_reset_vals: assert property (
      disable iff (1'b0) rst |=> rom_addr == RST_PROGRAM_COUNTER
      && !instr_valid && page_select == RST_PAGE_SELECT
      && timer_prescaler_config == RST_TIMER_PRESCALER
      && second_port_oe_n == RST_PORT_DIRECTION
      && first_port_oe_n == RST_PORT_A_DIRECTION)
      else $error("reset values wrong");
   a_page_write: assert property (
      go && exec_wr_en && exec_dst_addr == ADDR_CORE_FLAGS |=>
      page_select == 3'($past(exec_wr_data) >> 5))
      else $error("page bits not written");
   a_bubble_idle: assert property (
      phase_four && !instr_valid && exec_option_wr |=>
      $stable(timer_prescaler_config))
      else $error("flushed word took effect");

   c_jump: cover property (go && exec_branch && !exec_call);
   c_call: cover property (go && exec_branch && exec_call);
   c_status: cover property (go && exec_wr_en
      && exec_dst_addr == ADDR_CORE_FLAGS);
endmodule

// ===== testbench/ccs_core_test.sv
/*
 * Self-checking bench for ccs_core, acting as its execution unit.
 * Assumes ccs_pkg, ccs_core, ccs_rom_model and ccs_core_sva.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("[FAIL] %s exp %h got %h", nm, exp, got); \
      end \
   end
module ccs_core_test;
   import ccs_pkg::*;
   logic mclk = 1'b0;
   logic rst;
   logic phase_one, phase_two, phase_three, phase_four, instr_valid;
   logic [8:0] rom_addr, exec_branch_target;
   logic [11:0] rom_data, instr;
   logic [4:0] exec_src_addr, exec_dst_addr;
   logic [7:0] exec_src_data, exec_wr_data, second_port_in, rd;
   logic [7:0] second_port_out, second_port_oe_n;
   logic exec_wr_en, exec_branch, exec_call, exec_option_wr;
   logic exec_dir_wr, exec_dir_sel, reset_flag_load;
   logic timeout_flag_in, power_down_flag_in;
   logic [2:0] exec_flag_mask, exec_flag_value, page_select;
   logic [5:0] timer_prescaler_config;
   logic [3:0] first_port_in, first_port_out, first_port_oe_n;
   int fails = 0;
   int total_checks = 0;
   wire [3:0] phases = {phase_one, phase_two, phase_three, phase_four};

   ccs_core dut (.mclk, .rst, .phase_one, .phase_two, .phase_three,
      .phase_four, .rom_addr, .rom_data, .instr, .instr_valid,
      .exec_src_addr, .exec_src_data, .exec_wr_en, .exec_dst_addr,
      .exec_wr_data, .exec_flag_mask, .exec_flag_value, .exec_branch,
      .exec_call, .exec_branch_target, .exec_option_wr, .exec_dir_wr,
      .exec_dir_sel, .reset_flag_load, .timeout_flag_in,
      .power_down_flag_in, .timer_prescaler_config, .page_select,
      .first_port_in, .first_port_out, .first_port_oe_n,
      .second_port_in, .second_port_out, .second_port_oe_n);
   ccs_rom_model rom (.rom_addr, .rom_data);

   always #50 mclk = ~mclk;

   task automatic step(input int n = 1);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // One instruction cycle; fields stay held until the next call
   task automatic op(input logic [4:0] s, input logic w,
      input logic [4:0] d, input logic [7:0] v,
      input logic b = 0, input logic [8:0] t = 0,
      input logic [2:0] m = 0, input logic [2:0] fv = 0,
      input logic c = 0, input logic o = 0,
      input logic dw = 0, input logic ds = 0);
      int k;
      k = 0;
      while (phase_one !== 1'b1 && k < 8)
      begin
         step();
         k++;
      end
      exec_src_addr = s;
      exec_wr_en = w;
      exec_dst_addr = d;
      exec_wr_data = v;
      exec_branch = b;
      exec_branch_target = t;
      exec_flag_mask = m;
      exec_flag_value = fv;
      exec_call = c;
      exec_option_wr = o;
      exec_dir_wr = dw;
      exec_dir_sel = ds;
      step(2);
      rd = exec_src_data;
      step(2);
   endtask

   task automatic do_reset(input int n);
      rst = 1'b1;
      step(n);
      `CHK("rst addr", 9'h1ff, rom_addr)
      `CHK("rst option", 6'h3f, timer_prescaler_config)
      `CHK("rst page", 3'h0, page_select)
      `CHK("rst dir a", 4'hf, first_port_oe_n)
      `CHK("rst dir b", 8'hff, second_port_oe_n)
      rst = 1'b0;
   endtask

   task automatic t_start();
      `CHK("no prefetch", 1'b0, instr_valid)
      for (int i = 0; i < 4; i++)
      begin
         `CHK("phase", 4'h8 >> i, phases)
         step();
      end
      `CHK("vector word", 12'hbff, instr)
      `CHK("first valid", 1'b1, instr_valid)
      step();
      `CHK("rollover", 9'h000, rom_addr)
      step(3);
      `CHK("next word", 12'ha00, instr)
   endtask

   task automatic t_indirect();
      op(0, 1, 5'h15, 8'ha5);
      op(0, 1, 5'h04, 8'h15);
      op(5'h00, 0, 0, 0);
      `CHK("indirect rd", 8'ha5, rd)
      op(0, 1, 5'h00, 8'h5a);
      op(5'h15, 0, 0, 0);
      `CHK("direct rd", 8'h5a, rd)
      op(0, 1, 5'h04, 8'h00);
      op(0, 1, 5'h00, 8'h77);
      op(5'h00, 0, 0, 0);
      `CHK("self indirect", 8'h00, rd)
      op(0, 1, 5'h04, 8'h15);
   endtask

   task automatic t_ports();
      first_port_in = 4'hf;
      second_port_in = 8'h96;
      op(0, 0, 0, 8'h15, 0, 0, 0, 0, 0, 1);
      `CHK("option", 6'h15, timer_prescaler_config)
      op(0, 0, 0, 8'h0a, 0, 0, 0, 0, 0, 0, 1, 0);
      `CHK("dir a", 4'ha, first_port_oe_n)
      op(5'h05, 0, 0, 8'h3c, 0, 0, 0, 0, 0, 0, 1, 1);
      `CHK("dir b", 8'h3c, second_port_oe_n)
      `CHK("port a rd", 8'h0f, rd)
      op(5'h06, 1, 5'h06, 8'h5a);
      `CHK("port b rd", 8'h96, rd)
      `CHK("port b out", 8'h5a, second_port_out)
      op(0, 1, 5'h05, 8'hc9);
      `CHK("port a out", 4'h9, first_port_out)
   endtask

   task automatic t_status();
      reset_flag_load = 1'b1;
      timeout_flag_in = 1'b1;
      step();
      reset_flag_load = 1'b0;
      op(5'h04, 1, 5'h03, 8'hff);
      `CHK("ptr after rst", 8'h95, rd)
      op(5'h03, 1, 5'h03, 8'h00, 0, 0, 3'h4, 3'h4);
      `CHK("status wr", 8'hf7, rd)
      op(5'h03, 1, 5'h03, 8'hff, 0, 0, 3'h7, 3'h2);
      `CHK("clear op", 8'h17, rd)
      op(5'h03, 0, 0, 0);
      `CHK("flag wr", 8'hf2, rd)
      `CHK("page", 3'h7, page_select)
   endtask

   task automatic t_branch();
      op(0, 0, 0, 0, 1, 9'h1a0);
      `CHK("bubble", 1'b0, instr_valid)
      op(0, 1, 5'h15, 8'h33, 0, 0, 0, 0, 0, 1);
      `CHK("target word", 12'hba0, instr)
      `CHK("bubble option", 6'h3f, timer_prescaler_config)
      op(5'h15, 0, 0, 0);
      `CHK("bubble write", 8'h5a, rd)
      op(0, 1, 5'h02, 8'h33);
      step();
      `CHK("low byte jump", 9'h033, rom_addr)
      op(0, 0, 0, 0, 1, 9'h1c0);
      step();
      op(0, 0, 0, 0, 1, 9'h1c4, 0, 0, 1);
      step();
      `CHK("call target", 9'h0c4, rom_addr)
   endtask

   task automatic final_report();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      {exec_src_addr, exec_dst_addr, exec_wr_data} = '0;
      {exec_branch_target, exec_flag_mask, exec_flag_value} = '0;
      {exec_wr_en, exec_branch, exec_call, exec_option_wr} = '0;
      {exec_dir_wr, exec_dir_sel, reset_flag_load} = '0;
      {timeout_flag_in, power_down_flag_in} = '0;
      first_port_in = 4'h0;
      second_port_in = 8'h00;
      do_reset(10);
      t_start();
      t_indirect();
      t_ports();
      do_reset(2);
      t_start();
      t_status();
      t_branch();
      final_report();
   end

   // Whole run is about 150 cycles
   initial
   begin
      #200000;
      fails++;
      final_report();
   end
endmodule

bind ccs_core ccs_core_sva u_sva (.mclk, .rst, .phase_one, .phase_two,
   .phase_three, .phase_four, .rom_addr, .rom_data, .instr,
   .instr_valid, .exec_src_data, .exec_wr_en, .exec_dst_addr,
   .exec_wr_data, .exec_branch, .exec_call, .exec_branch_target,
   .exec_option_wr, .timer_prescaler_config, .page_select,
   .first_port_oe_n, .second_port_oe_n);

// ===== testbench/ccs_rom_model.sv
/*
 * Behavioural program ROM: 512 words of 12 bits.
 * Assumes the core reads it combinationally at rom_addr.
 */
`timescale 1ns/1ps
module ccs_rom_model
   import ccs_pkg::*;
(
   input wire logic [ccs_pkg::PC_W-1:0] rom_addr,
   output logic [ccs_pkg::INSTR_W-1:0] rom_data
);
   // Each word carries its own address, so fetch order shows
   assign rom_data = {3'h5, rom_addr};
endmodule
